// file: wdw_pkg.sv
// Constants, register map and timing for the windowed watchdog.
// Assumes a 100 MHz system clock and one AXI4-Lite master.
`default_nettype none
package wdw_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [1:0] CTRL_IDX = 2'h0;
  localparam logic [1:0] STAT_IDX = 2'h1;
  localparam logic [1:0] GUARD_IDX = 2'h2;
  // Control and status field positions.
  localparam int PER_LSB = 0;
  localparam int WIN_LSB = 4;
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  // Control value after reset, and the off and largest valid field codes.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;
  // Key that opens the change guard; the value is arbitrary.
  localparam logic [7:0] IO_REGISTER_KEY = 8'h5a;
  // Bus writes allowed after the key before the guard closes; reads do not count.
  localparam logic [2:0] GUARD_SLOTS = 3'h4;
  // Watchdog tick rate and the divider count derived from it.
  localparam int CLK_HZ = 100000000;
  localparam int TICK_HZ = 1024;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  // Ticks needed to carry a control write across.
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wdw_pkg
`default_nettype wire

// file: wdw_top.sv
// Windowed watchdog timer with an AXI4-Lite register slave.
// Assumes restart, debug and fuse inputs are synchronous to SYS_CLK.
//
// Design decision made here: the AXI4-Lite register port.
`default_nettype none
// Behaviour
// - Non-zero period field enables the watchdog.
// - Non-zero window field selects window mode.
// - Control and lock writes need guard unlock.
// - Fuse loads control; non-zero period sets lock.
// - Counter advances on a 1.024 kHz tick.
// - Normal mode resets after an unrestarted period.
// - Restart clears the count.
// - Eleven periods from about 8 ms to 8 s.
// - Zero window field means normal mode.
// - Restart in closed period causes reset.
// - Open period follows closed; late restart resets.
// - Closed window unenforced until first restart.
// - Lock sets only; debug clears; blocks control.
// - Counting continues through sleep modes.
// - Debug halt suspends and clears the counter.
// - After debug halt run one normal period.
// - Field writes cross over; busy flag meanwhile.
// - Restart acts two to three ticks later.
// - Key then protected write within four writes.
// - Unguarded protected writes leave registers unchanged.
// - Codes 1 to 11 give 8 to 8192 ticks.
// - Busy clears once the transfer completes.
module wdw_top #(
  parameter int TICK_DIV = wdw_pkg::TICK_DIV
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Core and debugger signals.
  input wire logic RESTART_PULSE,
  input wire logic DEBUG_HALT,
  input wire logic DEBUG_MODE,
  input wire logic [7:0] FUSE_CFG,
  // Watchdog reset output.
  output logic SYS_RESET_REQ,
  // AXI4-Lite write address.
  input wire logic [31:0] AXI_AWADDR,
  input wire logic AXI_AWVALID,
  output logic AXI_AWREADY,
  // AXI4-Lite write data.
  input wire logic [31:0] AXI_WDATA,
  input wire logic [3:0] AXI_WSTRB,
  input wire logic AXI_WVALID,
  output logic AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0] AXI_BRESP,
  output logic AXI_BVALID,
  input wire logic AXI_BREADY,
  // AXI4-Lite read address.
  input wire logic [31:0] AXI_ARADDR,
  input wire logic AXI_ARVALID,
  output logic AXI_ARREADY,
  // AXI4-Lite read data.
  output logic [31:0] AXI_RDATA,
  output logic [1:0] AXI_RRESP,
  output logic AXI_RVALID,
  input wire logic AXI_RREADY
);

  typedef enum logic [1:0] {WDW_OFF, WDW_NORMAL, WDW_WINDOW} wdw_mode_t;

  // Ticks selected by a period or window code; reserved codes clamp to the longest.
  function automatic logic [13:0] ticks_of(input logic [3:0] code);
    logic [13:0] t;
    t = 14'h0000;
    if (code == wdw_pkg::CODE_OFF) begin
      t = 14'h0000;
    end else if (code > wdw_pkg::CODE_MAX) begin
      t = 14'h2000;
    end else begin
      t = 14'h0004 << code;
    end
    return t;
  endfunction

  // Checks a byte address against the register map, flagging unmapped words.
  function automatic logic map_ok(input logic [31:0] addr);
    return (addr[31:4] == 28'h0000000) && (addr[3:2] <= wdw_pkg::GUARD_IDX);
  endfunction

  logic boot_q;
  logic [7:0] ctrl_q;
  logic lock_q;
  logic busy_q;
  logic [1:0] sync_cnt_q;
  logic [7:0] act_q;
  logic [16:0] div_q;
  logic tick_q;
  logic guard_open_q;
  logic [2:0] guard_left_q;
  logic restart_pend_q;
  logic [1:0] restart_pipe_q;
  logic [14:0] cnt_q;
  logic armed_q;
  logic rst_out_q;
  wdw_mode_t mode;

  // Bus slave state.
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic wr_fire;
  logic [1:0] wr_idx;
  logic wr_en;
  logic ctrl_wr;
  logic stat_wr;
  logic key_wr;
  logic apply_restart;
  logic [3:0] act_per;
  logic [3:0] act_win;
  logic [14:0] closed_len;
  logic [14:0] open_len;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = aw_addr_q[3:2];
  assign wr_en = wr_fire && map_ok(aw_addr_q) && w_lane_q;
  assign key_wr = wr_en && (wr_idx == wdw_pkg::GUARD_IDX)
    && (w_data_q == wdw_pkg::IO_REGISTER_KEY);
  assign ctrl_wr = wr_en && (wr_idx == wdw_pkg::CTRL_IDX)
    && guard_open_q && !lock_q;
  assign stat_wr = wr_en && (wr_idx == wdw_pkg::STAT_IDX) && guard_open_q;
  assign act_per = act_q[wdw_pkg::PER_LSB +: 4];
  assign act_win = act_q[wdw_pkg::WIN_LSB +: 4];
  assign closed_len = {1'b0, ticks_of(act_win)};
  assign open_len = {1'b0, ticks_of(act_per)};
  assign apply_restart = tick_q && restart_pipe_q[1];

  always_comb begin
    if (act_per == wdw_pkg::CODE_OFF) begin
      mode = WDW_OFF;
    end else if (act_win == wdw_pkg::CODE_OFF) begin
      mode = WDW_NORMAL;
    end else begin
      mode = WDW_WINDOW;
    end
  end

  // The tick is an enable from the system clock, so the watchdog runs as long as that clock does.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      div_q <= 17'h00000;
      tick_q <= 1'b0;
    end else if (div_q == 17'(TICK_DIV - 1)) begin
      div_q <= 17'h00000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  // The key opens the guard for a few writes; a protected write consumes it.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      guard_open_q <= 1'b0;
      guard_left_q <= 3'h0;
    end else if (key_wr) begin
      guard_open_q <= 1'b1;
      guard_left_q <= wdw_pkg::GUARD_SLOTS;
    end else if (wr_fire && guard_open_q) begin
      if (ctrl_wr || stat_wr || guard_left_q == 3'h1) begin
        guard_open_q <= 1'b0;
        guard_left_q <= 3'h0;
      end else begin
        guard_left_q <= guard_left_q - 3'h1;
      end
    end
  end

  // Control, lock and the crossing of written fields to the tick side.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      boot_q <= 1'b1;
      ctrl_q <= wdw_pkg::CTRL_RST;
      act_q <= wdw_pkg::CTRL_RST;
      lock_q <= 1'b0;
      busy_q <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      ctrl_q <= FUSE_CFG;
      act_q <= FUSE_CFG;
      lock_q <= (FUSE_CFG[wdw_pkg::PER_LSB +: 4] != wdw_pkg::CODE_OFF);
    end else begin
      if (stat_wr && w_data_q[wdw_pkg::LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (stat_wr && DEBUG_MODE) begin
        lock_q <= 1'b0;
      end
      // A new write restarts the transfer, so a late one is never lost.
      if (ctrl_wr) begin
        ctrl_q <= w_data_q;
        busy_q <= 1'b1;
        sync_cnt_q <= 2'h0;
      end else if (busy_q && tick_q) begin
        if (sync_cnt_q == wdw_pkg::SYNC_TICKS - 2'h1) begin
          act_q <= ctrl_q;
          busy_q <= 1'b0;
        end else begin
          sync_cnt_q <= sync_cnt_q + 2'h1;
        end
      end
    end
  end

  // Restarts ride a short tick-paced pipe, as they would through a real crossing.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      restart_pend_q <= 1'b0;
      restart_pipe_q <= 2'h0;
    end else begin
      if (RESTART_PULSE) begin
        restart_pend_q <= 1'b1;
      end else if (tick_q) begin
        restart_pend_q <= 1'b0;
      end
      if (tick_q) begin
        restart_pipe_q <= {restart_pipe_q[0], restart_pend_q};
      end
    end
  end

  // Counter and window logic on the tick.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      cnt_q <= 15'h0000;
      armed_q <= 1'b0;
      rst_out_q <= 1'b0;
    end else if (DEBUG_HALT) begin
      cnt_q <= 15'h0000;
      armed_q <= 1'b0;
      rst_out_q <= 1'b0;
    end else if (tick_q) begin
      rst_out_q <= 1'b0;
      if (mode == WDW_OFF) begin
        cnt_q <= 15'h0000;
        armed_q <= 1'b0;
      end else if (mode != WDW_WINDOW) begin
        armed_q <= 1'b0;
        if (apply_restart) begin
          cnt_q <= 15'h0000;
        end else if (cnt_q + 15'h0001 >= open_len) begin
          cnt_q <= 15'h0000;
          rst_out_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 15'h0001;
        end
      end else if (apply_restart) begin
        cnt_q <= 15'h0000;
        armed_q <= 1'b1;
        rst_out_q <= armed_q && (cnt_q < closed_len);
      end else if (cnt_q + 15'h0001 >= (armed_q ? closed_len + open_len : open_len)) begin
        cnt_q <= 15'h0000;
        rst_out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 15'h0001;
      end
    end
  end

  // Write channels; each ready stays low from its handshake until the response is taken.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= wdw_pkg::RESP_OKAY;
    end else begin
      if (AXI_AWVALID && awready_q) begin
        aw_addr_q <= AXI_AWADDR;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (AXI_WVALID && wready_q) begin
        w_data_q <= AXI_WDATA[7:0];
        w_lane_q <= AXI_WSTRB[0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= map_ok(aw_addr_q) ? wdw_pkg::RESP_OKAY : wdw_pkg::RESP_SLVERR;
      end else if (bvalid_q && AXI_BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= wdw_pkg::RESP_OKAY;
    end else if (AXI_ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= map_ok(AXI_ARADDR) ? wdw_pkg::RESP_OKAY : wdw_pkg::RESP_SLVERR;
      case (AXI_ARADDR[3:2])
        wdw_pkg::CTRL_IDX: rdata_q <= {24'h000000, ctrl_q};
        wdw_pkg::STAT_IDX: rdata_q <= {24'h000000, lock_q, 6'h00, busy_q};
        wdw_pkg::GUARD_IDX: rdata_q <= {31'h00000000, guard_open_q};
        default: rdata_q <= 32'h00000000;
      endcase
      if (!map_ok(AXI_ARADDR)) begin
        rdata_q <= 32'h00000000;
      end
    end else if (rvalid_q && AXI_RREADY) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign SYS_RESET_REQ = rst_out_q;
  assign AXI_AWREADY = awready_q;
  assign AXI_WREADY = wready_q;
  assign AXI_BRESP = bresp_q;
  assign AXI_BVALID = bvalid_q;
  assign AXI_ARREADY = arready_q;
  assign AXI_RDATA = rdata_q;
  assign AXI_RRESP = rresp_q;
  assign AXI_RVALID = rvalid_q;

endmodule // wdw_top
`default_nettype wire

// file: wdw_asserts.sv
// Checker for the watchdog's bus handshakes and reset pulse.
// Assumes binding to wdw_top; sees only its ports.
`default_nettype none
module wdw_asserts #(
  parameter int TICK_DIV = wdw_pkg::TICK_DIV
) (
  // Clock, reset and core lines.
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic DEBUG_HALT,
  input wire logic SYS_RESET_REQ,
  // Bus.
  input wire logic [31:0] AXI_AWADDR,
  input wire logic AXI_AWVALID,
  input wire logic AXI_AWREADY,
  input wire logic AXI_WVALID,
  input wire logic AXI_WREADY,
  input wire logic [1:0] AXI_BRESP,
  input wire logic AXI_BVALID,
  input wire logic AXI_BREADY,
  input wire logic [31:0] AXI_ARADDR,
  input wire logic AXI_ARVALID,
  input wire logic AXI_ARREADY,
  input wire logic [31:0] AXI_RDATA,
  input wire logic [1:0] AXI_RRESP,
  input wire logic AXI_RVALID
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  int hi_q;
  logic [31:0] ra_q;
  logic [31:0] wa_q;
  always_ff @(posedge SYS_CLK) begin
    hi_q <= (RST_B && SYS_RESET_REQ) ? hi_q + 1 : 0;
  end
  always_ff @(posedge SYS_CLK) begin
    if (AXI_ARVALID && AXI_ARREADY) begin
      ra_q <= AXI_ARADDR;
    end
    if (AXI_AWVALID && AXI_AWREADY) begin
      wa_q <= AXI_AWADDR;
    end
  end
  // The response needs one cycle to pair the channels, so it stands two cycles after the take.
  write_take_a: assert property (AXI_AWVALID && AXI_AWREADY && AXI_WVALID && AXI_WREADY
    |=> !AXI_BVALID && !AXI_AWREADY && !AXI_WREADY ##1 AXI_BVALID)
    else $error("write answer wrong");
  write_resp_a: assert property (AXI_BVALID |-> AXI_BRESP == (wa_q > 32'h0000000b ?
    wdw_pkg::RESP_SLVERR : wdw_pkg::RESP_OKAY)) else $error("write response wrong");
  write_done_a: assert property (AXI_BVALID && AXI_BREADY
    |=> !AXI_BVALID && AXI_AWREADY && AXI_WREADY) else $error("write release wrong");
  read_take_a: assert property (AXI_ARVALID && AXI_ARREADY
    |=> AXI_RVALID && !AXI_ARREADY) else $error("read answer wrong");
  read_upper_a: assert property (AXI_RVALID |-> AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  bad_read_a: assert property (AXI_RVALID && ra_q > 32'h0000000b
    |-> AXI_RRESP == wdw_pkg::RESP_SLVERR && AXI_RDATA == 32'h0) else $error("bad read");
  stat_rsvd_a: assert property (AXI_RVALID && ra_q == 32'h00000004
    |-> AXI_RDATA[6:1] == 6'h00) else $error("status spare bits set");
  pulse_max_a: assert property (SYS_RESET_REQ |-> hi_q < TICK_DIV)
    else $error("reset pulse too long");
  pulse_len_a: assert property ($fell(SYS_RESET_REQ) && !$past(DEBUG_HALT)
    |-> hi_q == TICK_DIV) else $error("reset pulse too short");
  halt_quiet_a: assert property ($past(DEBUG_HALT) && DEBUG_HALT
    |-> !SYS_RESET_REQ) else $error("reset during halt");
  cover property ($rose(SYS_RESET_REQ));
  cover property (AXI_RVALID && AXI_RRESP == wdw_pkg::RESP_SLVERR);
  cover property (DEBUG_HALT && !SYS_RESET_REQ);
endmodule // wdw_asserts
bind wdw_top wdw_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.*);
`default_nettype wire

// file: wdw_cpu_model.sv
// CPU core model: bus master for the registers, restart and debugger lines.
// Assumes one clock shared with the watchdog.
`default_nettype none
module wdw_cpu_model (
  // Clock.
  input wire logic clk,
  // Write channels.
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels.
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready,
  // Core and debugger lines.
  output logic restart,
  output logic halt,
  output logic dbg
);
  logic hung;
  initial begin
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, restart, halt, dbg, hung} = '0;
    wstrb = 4'h1;
  end
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hung |= (n == 40);
    bready <= 1'b0;
    awaddr <= ~a;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hung |= (n == 40);
    d = rdata;
    rready <= 1'b0;
    araddr <= ~a;
  endtask
  // The key opens the guard only for the next four writes, so the protected write follows at once.
  task automatic guarded(input logic [31:0] a, input logic [7:0] d);
    wr(32'({wdw_pkg::GUARD_IDX, 2'h0}), wdw_pkg::IO_REGISTER_KEY);
    wr(a, d);
  endtask
  task automatic kick();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask
  task automatic set_dbg(input logic h, input logic m);
    @(posedge clk);
    halt <= h;
    dbg <= m;
  endtask
endmodule // wdw_cpu_model
`default_nettype wire

// file: windowed_watchdog_timer_tb.sv
// Testbench: lock, register, timing, window and debug tests of the watchdog.
// Assumes a shortened tick divider; the CPU model drives the restart and debug inputs.
`default_nettype none
module windowed_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 8;
  localparam logic [31:0] A_CTRL = 32'({wdw_pkg::CTRL_IDX, 2'h0});
  localparam logic [31:0] A_STAT = 32'({wdw_pkg::STAT_IDX, 2'h0});
  localparam logic [31:0] A_GUARD = 32'({wdw_pkg::GUARD_IDX, 2'h0});
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] fuse = 8'h00;
  logic rs, hlt, dm, req, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [31:0] awa, wd, ara, rdat;
  logic [3:0] ws;
  logic [1:0] brsp, rrsp;
  int error_cnt = 0;
  int n_checks = 0;
  int n_rst = 0;
  int c, n0;
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge req) n_rst++;
  wdw_top #(.TICK_DIV(TD)) dut (.SYS_CLK(clk), .RST_B(rst_b), .RESTART_PULSE(rs),
    .DEBUG_HALT(hlt), .DEBUG_MODE(dm), .FUSE_CFG(fuse), .SYS_RESET_REQ(req),
    .AXI_AWADDR(awa), .AXI_AWVALID(awv), .AXI_AWREADY(awr), .AXI_WDATA(wd),
    .AXI_WSTRB(ws), .AXI_WVALID(wv), .AXI_WREADY(wrdy), .AXI_BRESP(brsp),
    .AXI_BVALID(bv), .AXI_BREADY(br), .AXI_ARADDR(ara), .AXI_ARVALID(arv),
    .AXI_ARREADY(arr), .AXI_RDATA(rdat), .AXI_RRESP(rrsp), .AXI_RVALID(rv),
    .AXI_RREADY(rr));
  wdw_cpu_model u_cpu (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr),
    .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wrdy), .bvalid(bv), .bready(br),
    .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdat), .rvalid(rv),
    .rready(rr), .restart(rs), .halt(hlt), .dbg(dm));
  task automatic end_sim();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (u_cpu.hung) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_cpu.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic boot(input logic [7:0] f);
    rst_b <= 1'b0;
    fuse <= f;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  task automatic idle(input int t);
    repeat (t * TD) @(posedge clk);
  endtask
  // A hung wait would hide every later check, so it ends the run.
  task automatic wait_rst(output int n);
    logic p;
    p = req;
    for (n = 1; n <= 3000; n++) begin
      @(posedge clk);
      if (req && !p) break;
      p = req;
    end
    if (n > 3000) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic sync_wait();
    logic [31:0] d;
    int n;
    for (n = 0; n < 20; n++) begin
      u_cpu.rd(A_STAT, d);
      if (d[0] === 1'b0) break;
    end
    chk("busy", 32'(d[0]), 32'h0);
    if (n == 20) end_sim();
  endtask
  initial begin
    boot(8'h0b);
    rc(A_CTRL, 32'h0b);
    rc(A_STAT, 32'h80);
    u_cpu.guarded(A_CTRL, 8'h00);
    rc(A_CTRL, 32'h0b);
    u_cpu.guarded(A_STAT, 8'h00);
    rc(A_STAT, 32'h80);
    rc(A_GUARD, 32'h00);
    u_cpu.set_dbg(1'b0, 1'b1);
    u_cpu.wr(A_STAT, 8'h00);
    rc(A_STAT, 32'h80);
    u_cpu.guarded(A_STAT, 8'h00);
    rc(A_STAT, 32'h00);
    u_cpu.guarded(A_STAT, 8'h80);
    rc(A_STAT, 32'h80);
    u_cpu.set_dbg(1'b0, 1'b0);
    $display("Test lock done");
    boot(8'h00);
    n0 = n_rst;
    u_cpu.wr(A_GUARD, wdw_pkg::IO_REGISTER_KEY);
    rc(A_GUARD, 32'h01);
    repeat (4) u_cpu.wr(A_GUARD, 8'h00);
    rc(A_GUARD, 32'h00);
    u_cpu.wr(A_CTRL, 8'h01);
    rc(A_CTRL, 32'h00);
    rc(32'h0000000c, 32'h00);
    u_cpu.wr(32'h0000000c, 8'h01);
    idle(20);
    chk("idle resets", n_rst, n0);
    for (int k = 1; k <= 3; k++) begin
      u_cpu.guarded(A_CTRL, 8'(k));
      rc(A_STAT, 32'h01);
      sync_wait();
      wait_rst(c);
      wait_rst(c);
      chk("period", c, (8 << (k - 1)) * TD);
    end
    n0 = n_rst;
    repeat (12) begin
      u_cpu.kick();
      idle(4);
    end
    chk("kicked resets", n_rst, n0);
    $display("Test normal done");
    u_cpu.guarded(A_CTRL, 8'h11);
    sync_wait();
    wait_rst(c);
    chk("unarmed", 32'(c <= 9 * TD), 32'h1);
    n0 = n_rst;
    u_cpu.kick();
    idle(12);
    u_cpu.kick();
    idle(3);
    chk("open resets", n_rst, n0);
    u_cpu.kick();
    wait_rst(c);
    chk("early kick", 32'(c < 8 * TD), 32'h1);
    $display("Test window done");
    idle(2);
    n0 = n_rst;
    u_cpu.set_dbg(1'b1, 1'b0);
    idle(20);
    chk("halt resets", n_rst, n0);
    u_cpu.set_dbg(1'b0, 1'b0);
    wait_rst(c);
    chk("resume", 32'(c >= 6 * TD && c <= 9 * TD), 32'h1);
    $display("Test debug done");
    end_sim();
  end
endmodule // windowed_watchdog_timer_tb
`default_nettype wire
